// file: rtl/shared_io_pkg.sv
// constants for the shared i/o port with change notification
// Operation
// - per-pin muxes give output to peripheral or port
// - port output never loops into peripheral input
// - driving peripheral disables port driver, pin readable
// - idle enabled peripheral lets port drive pin
// - direction bit one is input, zero output
// - reset sets all implemented direction bits
// - latch reads and writes the latch
// - port read gives pins, write goes to latch
// - unimplemented bits read zero in direction, latch and port; open-drain and analog store them
// - input-only sharing pin stays a port pin
// - open-drain bit: drive low only, release high
// - analog-configured pins read low in port
// - selected change inputs raise interrupt, up to 31
// - change detection works with clocks stopped
// - per-input interrupt enables in two registers
// - per-input weak pull-up bits in two registers
package shared_io_pkg;

    // ****************************************************
    // register byte offsets
    // ****************************************************
    localparam logic [11:0] PIN_DIRECTION_OFF  = 12'h000;
    localparam logic [11:0] OUTPUT_LATCH_OFF   = 12'h004;
    localparam logic [11:0] PIN_LEVEL_OFF      = 12'h008;
    localparam logic [11:0] OPEN_DRAIN_OFF     = 12'h00C;
    localparam logic [11:0] ANALOG_CONFIG_OFF  = 12'h010;
    localparam logic [11:0] CHANGE_EN_LO_OFF   = 12'h014;
    localparam logic [11:0] CHANGE_EN_HI_OFF   = 12'h018;
    localparam logic [11:0] PULLUP_EN_LO_OFF   = 12'h01C;
    localparam logic [11:0] PULLUP_EN_HI_OFF   = 12'h020;
    localparam logic [11:0] CHANGE_FLAG_OFF    = 12'h024;

    // ****************************************************
    // field layout and reset values
    // ****************************************************
    localparam int          CN_LO_WIDTH        = 16;
    localparam logic [31:0] DIRECTION_RESET    = 32'hFFFF_FFFF;
    localparam logic [31:0] CLEAR_RESET        = 32'h0000_0000;

    // ****************************************************
    // bus answers
    // ****************************************************
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

endpackage : shared_io_pkg

// file: rtl/io_pin_cell.sv
// one pin: ownership muxes, open-drain and loop-through blocking
`timescale 1ns/1ps
module io_pin_cell (
    // port state
    input  wire logic latch_bit,
    input  wire logic dir_bit,
    input  wire logic od_bit,
    input  wire logic impl_bit,
    input  wire logic input_only_bit,
    // sharing peripheral
    input  wire logic periph_en,
    input  wire logic periph_drive,
    input  wire logic periph_out,
    output logic      periph_in,
    // pad
    input  wire logic pad_level,
    output logic      pad_out,
    output logic      pad_oe
);
    logic periph_owns;
    logic port_drive;
    logic drive_val;
    logic drive_en;

    always_comb begin
        // input-only sharers never compete for the driver
        periph_owns = impl_bit & ~input_only_bit & periph_en & periph_drive;
        port_drive  = impl_bit & ~dir_bit & ~periph_owns;
        drive_val   = periph_owns ? periph_out : latch_bit;
        drive_en    = periph_owns | port_drive;
        pad_oe      = drive_en & ~(od_bit & drive_val);
        pad_out     = drive_val & ~od_bit & drive_en;
        // peripheral never sees the port's own drive
        periph_in   = pad_level & ~port_drive;
    end

endmodule : io_pin_cell

// file: rtl/shared_io_port.sv
// shared i/o port with change notification, axi4-lite register slave
`timescale 1ns/1ps
module shared_io_port #(
    parameter int                N_PINS          = 16,
    parameter int                CN_COUNT        = 31,
    parameter logic [N_PINS-1:0] IMPL_MASK       = '1,
    parameter logic [N_PINS-1:0] INPUT_ONLY_MASK = '0
) (
    // clock, reset, enable
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic                ce,
    // axi4-lite write address
    input  wire logic [11:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // axi4-lite read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // port pads
    input  wire logic [N_PINS-1:0]   pad_in,
    output logic [N_PINS-1:0]        pad_out,
    output logic [N_PINS-1:0]        pad_oe,
    // sharing peripherals
    input  wire logic [N_PINS-1:0]   periph_enable,
    input  wire logic [N_PINS-1:0]   periph_drive,
    input  wire logic [N_PINS-1:0]   periph_out,
    output logic [N_PINS-1:0]        periph_in,
    // change notification pins
    input  wire logic [CN_COUNT-1:0] change_notify_input,
    output logic [CN_COUNT-1:0]      pullup_enable,
    output logic                     change_irq,
    output logic                     wake_request
);
    localparam int LO_W = shared_io_pkg::CN_LO_WIDTH;
    localparam int HI_W = CN_COUNT - LO_W;

    // ****************************************************
    // state
    // ****************************************************
    logic [N_PINS-1:0]   pin_direction_reg, pin_direction_next;
    logic [N_PINS-1:0]   output_latch_reg, output_latch_next;
    logic [N_PINS-1:0]   open_drain_select_reg, open_drain_select_next;
    logic [N_PINS-1:0]   analog_pin_config_reg, analog_pin_config_next;
    logic [LO_W-1:0]     change_irq_enable_lo_reg, change_irq_enable_lo_next;
    logic [HI_W-1:0]     change_irq_enable_hi_reg, change_irq_enable_hi_next;
    logic [LO_W-1:0]     weak_pullup_enable_lo_reg, weak_pullup_enable_lo_next;
    logic [HI_W-1:0]     weak_pullup_enable_hi_reg, weak_pullup_enable_hi_next;
    logic [CN_COUNT-1:0] change_flag_reg, change_flag_next;

    logic [N_PINS-1:0]   pad_meta_reg, pad_sync_reg;
    logic [CN_COUNT-1:0] cn_meta_reg, cn_sync_reg, cn_prev_reg;
    logic                cn_primed_reg, cn_primed_next;

    logic                aw_held_reg, aw_held_next;
    logic [11:0]         awaddr_reg, awaddr_next;
    logic                w_held_reg, w_held_next;
    logic [31:0]         wdata_reg, wdata_next;
    logic [3:0]          wstrb_reg, wstrb_next;
    logic                bvalid_reg, bvalid_next;
    logic [1:0]          bresp_reg, bresp_next;
    logic                rvalid_reg, rvalid_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic [1:0]          rresp_reg, rresp_next;

    logic [CN_COUNT-1:0] cn_enable;
    logic [N_PINS-1:0]   pin_level_view;
    logic                do_write;
    logic [11:0]         wr_word;
    logic [11:0]         rd_word;
    logic [31:0]         rd_value;
    logic                rd_hit;
    logic                wr_hit;
    logic [31:0]         merged;
    logic [31:0]         old_value;

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // ****************************************************
    // pin cells
    // ****************************************************
    for (genvar i = 0; i < N_PINS; i++) begin : g_pin
        io_pin_cell u_cell (
            .latch_bit      (output_latch_reg[i]),
            .dir_bit        (pin_direction_reg[i]),
            .od_bit         (open_drain_select_reg[i]),
            .impl_bit       (IMPL_MASK[i]),
            .input_only_bit (INPUT_ONLY_MASK[i]),
            .periph_en      (periph_enable[i]),
            .periph_drive   (periph_drive[i]),
            .periph_out     (periph_out[i]),
            .periph_in      (periph_in[i]),
            .pad_level      (pad_sync_reg[i]),
            .pad_out        (pad_out[i]),
            .pad_oe         (pad_oe[i])
        );
    end

    // ****************************************************
    // change notification
    // ****************************************************
    always_comb begin
        cn_enable      = {change_irq_enable_hi_reg, change_irq_enable_lo_reg};
        pullup_enable  = {weak_pullup_enable_hi_reg, weak_pullup_enable_lo_reg};
        cn_primed_next = 1'b1;
        // first sample after reset has no history to compare against
        change_flag_next = change_flag_reg;
        if (do_write && wr_word == shared_io_pkg::CHANGE_FLAG_OFF) begin
            change_flag_next = change_flag_reg & ~merged[CN_COUNT-1:0];
        end
        if (cn_primed_reg) begin
            change_flag_next = change_flag_next | (cn_enable & (cn_sync_reg ^ cn_prev_reg));
        end
        change_irq = |change_flag_reg;

        // asynchronous path: still answers while the clock is stopped in sleep
        wake_request = |(cn_enable & (change_notify_input ^ cn_prev_reg));
    end

    // ****************************************************
    // axi4-lite handshakes
    // ****************************************************
    always_comb begin
        s_axi_awready = ce & ~aw_held_reg;
        s_axi_wready  = ce & ~w_held_reg;
        s_axi_arready = ce & ~rvalid_reg;
        s_axi_bvalid  = bvalid_reg;
        s_axi_bresp   = bresp_reg;
        s_axi_rvalid  = rvalid_reg;
        s_axi_rdata   = rdata_reg;
        s_axi_rresp   = rresp_reg;
        do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;
        wr_word       = {awaddr_reg[11:2], 2'b00};
        rd_word       = {s_axi_araddr[11:2], 2'b00};
    end

    // ****************************************************
    // read decode
    // ****************************************************
    always_comb begin
        pin_level_view = pad_sync_reg & ~analog_pin_config_reg & IMPL_MASK;
        rd_hit   = 1'b1;
        rd_value = 32'h0000_0000;

        case (rd_word)
            shared_io_pkg::PIN_DIRECTION_OFF: rd_value = 32'(pin_direction_reg);
            shared_io_pkg::OUTPUT_LATCH_OFF:  rd_value = 32'(output_latch_reg);
            shared_io_pkg::PIN_LEVEL_OFF:     rd_value = 32'(pin_level_view);
            shared_io_pkg::OPEN_DRAIN_OFF:    rd_value = 32'(open_drain_select_reg);
            shared_io_pkg::ANALOG_CONFIG_OFF: rd_value = 32'(analog_pin_config_reg);
            shared_io_pkg::CHANGE_EN_LO_OFF:  rd_value = 32'(change_irq_enable_lo_reg);
            shared_io_pkg::CHANGE_EN_HI_OFF:  rd_value = 32'(change_irq_enable_hi_reg);
            shared_io_pkg::PULLUP_EN_LO_OFF:  rd_value = 32'(weak_pullup_enable_lo_reg);
            shared_io_pkg::PULLUP_EN_HI_OFF:  rd_value = 32'(weak_pullup_enable_hi_reg);
            shared_io_pkg::CHANGE_FLAG_OFF:   rd_value = 32'(change_flag_reg);
            default:                          rd_hit   = 1'b0;
        endcase
    end

    // ****************************************************
    // write decode and register next values
    // ****************************************************
    always_comb begin
        wr_hit    = 1'b1;
        old_value = 32'h0000_0000;
        case (wr_word)
            shared_io_pkg::PIN_DIRECTION_OFF: old_value = 32'(pin_direction_reg);
            shared_io_pkg::OUTPUT_LATCH_OFF,
            shared_io_pkg::PIN_LEVEL_OFF:     old_value = 32'(output_latch_reg);
            shared_io_pkg::OPEN_DRAIN_OFF:    old_value = 32'(open_drain_select_reg);
            shared_io_pkg::ANALOG_CONFIG_OFF: old_value = 32'(analog_pin_config_reg);
            shared_io_pkg::CHANGE_EN_LO_OFF:  old_value = 32'(change_irq_enable_lo_reg);
            shared_io_pkg::CHANGE_EN_HI_OFF:  old_value = 32'(change_irq_enable_hi_reg);
            shared_io_pkg::PULLUP_EN_LO_OFF:  old_value = 32'(weak_pullup_enable_lo_reg);
            shared_io_pkg::PULLUP_EN_HI_OFF:  old_value = 32'(weak_pullup_enable_hi_reg);
            shared_io_pkg::CHANGE_FLAG_OFF:   old_value = 32'h0000_0000;
            default:                          wr_hit    = 1'b0;
        endcase
        // flag clear uses only the strobed bytes of wdata
        merged = merge_bytes(old_value, wdata_reg, wstrb_reg);

        pin_direction_next         = pin_direction_reg;
        output_latch_next          = output_latch_reg;
        open_drain_select_next     = open_drain_select_reg;
        analog_pin_config_next     = analog_pin_config_reg;
        change_irq_enable_lo_next  = change_irq_enable_lo_reg;
        change_irq_enable_hi_next  = change_irq_enable_hi_reg;
        weak_pullup_enable_lo_next = weak_pullup_enable_lo_reg;
        weak_pullup_enable_hi_next = weak_pullup_enable_hi_reg;

        if (do_write) begin
            case (wr_word)
                shared_io_pkg::PIN_DIRECTION_OFF: pin_direction_next = merged[N_PINS-1:0] & IMPL_MASK;
                shared_io_pkg::OUTPUT_LATCH_OFF,
                shared_io_pkg::PIN_LEVEL_OFF:     output_latch_next = merged[N_PINS-1:0] & IMPL_MASK;
                shared_io_pkg::OPEN_DRAIN_OFF:    open_drain_select_next = merged[N_PINS-1:0];
                shared_io_pkg::ANALOG_CONFIG_OFF: analog_pin_config_next = merged[N_PINS-1:0];
                shared_io_pkg::CHANGE_EN_LO_OFF:  change_irq_enable_lo_next = merged[LO_W-1:0];
                shared_io_pkg::CHANGE_EN_HI_OFF:  change_irq_enable_hi_next = merged[HI_W-1:0];
                shared_io_pkg::PULLUP_EN_LO_OFF:  weak_pullup_enable_lo_next = merged[LO_W-1:0];
                shared_io_pkg::PULLUP_EN_HI_OFF:  weak_pullup_enable_hi_next = merged[HI_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************
    // bus channel next values
    // ****************************************************
    always_comb begin
        aw_held_next = aw_held_reg;
        awaddr_next  = awaddr_reg;
        w_held_next  = w_held_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;

        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit ? shared_io_pkg::RESP_OKAY : shared_io_pkg::RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_value;
            rresp_next  = rd_hit ? shared_io_pkg::RESP_OKAY : shared_io_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_direction_reg <= shared_io_pkg::DIRECTION_RESET[N_PINS-1:0] & IMPL_MASK;
            output_latch_reg <= '0;
            open_drain_select_reg <= '0;
            analog_pin_config_reg <= '0;
            change_irq_enable_lo_reg <= '0;
            change_irq_enable_hi_reg <= '0;
            weak_pullup_enable_lo_reg <= '0;
            weak_pullup_enable_hi_reg <= '0;

            change_flag_reg <= '0;

            pad_meta_reg <= '0;
            pad_sync_reg <= '0;

            cn_meta_reg <= '0;
            cn_sync_reg <= '0;
            cn_prev_reg <= '0;
            cn_primed_reg <= 1'b0;

            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
            w_held_reg <= 1'b0;
            wdata_reg <= shared_io_pkg::CLEAR_RESET;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= shared_io_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= shared_io_pkg::CLEAR_RESET;
            rresp_reg <= shared_io_pkg::RESP_OKAY;
        end else if (ce) begin
            pin_direction_reg <= pin_direction_next;
            output_latch_reg <= output_latch_next;
            open_drain_select_reg <= open_drain_select_next;
            analog_pin_config_reg <= analog_pin_config_next;
            change_irq_enable_lo_reg <= change_irq_enable_lo_next;
            change_irq_enable_hi_reg <= change_irq_enable_hi_next;
            weak_pullup_enable_lo_reg <= weak_pullup_enable_lo_next;
            weak_pullup_enable_hi_reg <= weak_pullup_enable_hi_next;

            change_flag_reg <= change_flag_next;

            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;

            cn_meta_reg <= change_notify_input;
            cn_sync_reg <= cn_meta_reg;
            cn_prev_reg <= cn_sync_reg;
            cn_primed_reg <= cn_primed_next;

            aw_held_reg <= aw_held_next;
            awaddr_reg <= awaddr_next;
            w_held_reg <= w_held_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

endmodule : shared_io_port

// file: tb/shared_io_port_props.sv
// assertion checker for the shared i/o port
`timescale 1ns/1ps
module shared_io_port_props #(
    parameter int                N_PINS          = 16,
    parameter int                CN_COUNT        = 31,
    parameter logic [N_PINS-1:0] INPUT_ONLY_MASK = '0
) (
    // clock, reset, bus handshakes
    input wire logic                clk_sys, rstn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic                s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    // pins
    input wire logic [N_PINS-1:0]   pad_out, pad_oe, periph_enable, periph_drive, periph_out, periph_in,
    input wire logic [CN_COUNT-1:0] change_notify_input, pullup_enable,
    input wire logic                change_irq
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic [N_PINS-1:0] own = periph_enable & periph_drive & ~INPUT_ONLY_MASK;
    logic [CN_COUNT-1:0]    cn_prev_reg;
    logic [3:0]             quiet_reg, quiet_next;
    // cycles since a change pin last moved, saturating so it never wraps
    always_comb quiet_next = (change_notify_input != cn_prev_reg) ? 4'h0 : quiet_reg + 4'(quiet_reg != 4'hF);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cn_prev_reg <= '0;
            quiet_reg   <= 4'hF;
        end else begin
            cn_prev_reg <= change_notify_input;
            quiet_reg   <= quiet_next;
        end
    end
    a_periph_owns: assert property ((pad_oe & own & (pad_out ^ periph_out)) == '0)
        else $error("owned pin not carrying peripheral value");
    a_no_loop: assert property ((pad_oe & ~own & periph_in) == '0)
        else $error("port output reaches peripheral input");
    a_reset_input: assert property ($rose(rstn) |-> (pad_oe & ~own) == '0)
        else $error("port drives a pin after reset");
    a_pullup_reset: assert property ($rose(rstn) |-> pullup_enable == '0)
        else $error("pull-up on after reset");
    a_irq_cause: assert property ($rose(change_irq) |-> quiet_reg <= 4'h4)
        else $error("change interrupt without recent pin change");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property
        ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) ##0 ce [*3] |-> s_axi_bvalid)
        else $error("write answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_ce_refuses: assert property (!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
        else $error("request accepted with clock enable low");
endmodule : shared_io_port_props
bind shared_io_port shared_io_port_props #(.N_PINS(N_PINS), .CN_COUNT(CN_COUNT), .INPUT_ONLY_MASK(INPUT_ONLY_MASK))
    u_props (.clk_sys, .rstn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pad_out, .pad_oe, .periph_enable, .periph_drive, .periph_out,
    .periph_in, .change_notify_input, .pullup_enable, .change_irq);

// file: tb/pin_world.sv
// external circuitry on the shared pads
`timescale 1ns/1ps
module pin_world (
    input wire logic [15:0] pad_out, pad_oe, ext_en, ext_val,
    output logic     [15:0] pad_in
);
    // undriven pads rest at the board pull-up, which open-drain highs rely on
    always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en);
endmodule : pin_world

// file: tb/shared_io_port_tb.sv
// self-checking bench for the shared i/o port
`timescale 1ns/1ps
module shared_io_port_tb;
    localparam logic [15:0] IMPL = 16'h7FFF;
    localparam logic [15:0] IN_ONLY = 16'h4000;
    logic        clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, change_irq, wake_request;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rnd = 32'hB66C_9B41, m_lat, m_en;
    logic [15:0] pad_in, pad_out, pad_oe, periph_in, own, periph_enable = '0, periph_drive = '0, periph_out = '0;
    logic [15:0] ext_en = '0, ext_val = '0;
    logic [30:0] change_notify_input = '0, pullup_enable;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    shared_io_port #(.IMPL_MASK(IMPL), .INPUT_ONLY_MASK(IN_ONLY)) uut (.clk_sys, .rstn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe, .periph_enable, .periph_drive, .periph_out,
        .periph_in, .change_notify_input, .pullup_enable, .change_irq, .wake_request);
    pin_world u_pins (.pad_out, .pad_oe, .ext_en, .ext_val, .pad_in);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            // readies are combinational: sample them settled, ahead of the edge
            @(negedge clk_sys);
            {aw, w, b, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic ar, r;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(negedge clk_sys);
            {ar, r, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rresp};
            if (r === 1'b1) check(n, e, s_axi_rdata);
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (r !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(shared_io_pkg::PIN_DIRECTION_OFF, 32'(IMPL), "dir_reset");
        rnd = lfsr(rnd);
        wr(shared_io_pkg::OUTPUT_LATCH_OFF, rnd);
        m_lat = rnd & 32'(IMPL);
        rd(shared_io_pkg::OUTPUT_LATCH_OFF, m_lat, "latch");
        wr(shared_io_pkg::PIN_LEVEL_OFF, ~rnd);
        m_lat = ~rnd & 32'(IMPL);
        rd(shared_io_pkg::OUTPUT_LATCH_OFF, m_lat, "port_write");
        wr(shared_io_pkg::PIN_DIRECTION_OFF, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            periph_enable <= rnd[15:0];
            periph_drive  <= rnd[31:16];
            periph_out    <= rnd[23:8];
            repeat (4) @(posedge clk_sys);
            own = periph_enable & periph_drive & ~IN_ONLY;
            check("pad_oe", 32'(IMPL), 32'(pad_oe));
            check("pad_out", 32'(IMPL & ((own & periph_out) | (~own & m_lat[15:0]))), 32'(pad_out & IMPL));
            check("periph_in", 32'(own & periph_out), 32'(periph_in & IMPL));
        end
        periph_enable <= 16'h0000;
        repeat (3) @(posedge clk_sys);
        rd(shared_io_pkg::PIN_LEVEL_OFF, m_lat, "pin_level");
        $display("test ownership done");
        wr(shared_io_pkg::OPEN_DRAIN_OFF, 32'h0000_FFFF);
        check("od_out", 32'h0000_0000, 32'(pad_out));
        check("od_oe", 32'(IMPL & ~m_lat[15:0]), 32'(pad_oe));
        rd(shared_io_pkg::PIN_LEVEL_OFF, m_lat, "od_level");
        // analog pins kept as inputs so the sampled level is the pad's own
        wr(shared_io_pkg::PIN_DIRECTION_OFF, 32'h0000_FFFF);
        rnd = lfsr(rnd);
        ext_en  <= 16'hFFFF;
        ext_val <= rnd[15:0];
        wr(shared_io_pkg::ANALOG_CONFIG_OFF, 32'h0000_00FF);
        rd(shared_io_pkg::PIN_LEVEL_OFF, 32'(IMPL & 16'hFF00 & rnd[15:0]), "analog");
        $display("test pad modes done");
        rnd = lfsr(rnd);
        m_en = rnd;
        wr(shared_io_pkg::CHANGE_EN_LO_OFF, {16'h0000, m_en[15:0]});
        wr(shared_io_pkg::CHANGE_EN_HI_OFF, {17'h0_0000, m_en[30:16]});
        rnd = lfsr(rnd);
        change_notify_input <= change_notify_input ^ rnd[30:0];
        #1 check("wake", 32'((m_en[30:0] & rnd[30:0]) != 31'h0), 32'(wake_request));
        repeat (6) @(posedge clk_sys);
        check("irq", 32'((m_en[30:0] & rnd[30:0]) != 31'h0), 32'(change_irq));
        rd(shared_io_pkg::CHANGE_FLAG_OFF, {1'b0, m_en[30:0] & rnd[30:0]}, "flags");
        wr(shared_io_pkg::CHANGE_FLAG_OFF, 32'h7FFF_FFFF);
        rd(shared_io_pkg::CHANGE_FLAG_OFF, 32'h0000_0000, "flags_clear");
        // every pin is an input here, so pull-ups are safe to enable
        rnd = lfsr(rnd);
        wr(shared_io_pkg::PULLUP_EN_LO_OFF, {16'h0000, rnd[15:0]});
        wr(shared_io_pkg::PULLUP_EN_HI_OFF, {17'h0_0000, rnd[30:16]});
        check("pullup", {1'b0, rnd[30:0]}, 32'(pullup_enable));
        $display("test change notify done");
        wr(12'h040, 32'h0000_0001);
        check("bresp", 32'(shared_io_pkg::RESP_SLVERR), 32'(resp));
        rd(12'h040, 32'h0000_0000, "unmapped");
        check("rresp", 32'(shared_io_pkg::RESP_SLVERR), 32'(resp));
        ce <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ce <= 1'b1;
        $display("test refusals done");
        print_verdict();
    end
endmodule : shared_io_port_tb
